// File: src/timer_defs.svh
// constants for the three-channel timer block: channel count, widths, reset values, pin high level
// assumes inclusion by bare name from design files only
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

`define TMR_CH_COUNT 3
`define TMR_CNT_W 24
`define TMR_PRESC_W 8
`define TMR_CNT_RST 24'h000000
`define TMR_PRESC_RST 8'h00
`define TMR_PWM_HIGH 1'b1

`endif

// File: src/timer_pkg.sv
// types shared by the timer block
// assumes timer_defs.svh is visible on the include path
package timer_pkg;

   // pin function selected in the control/status bits
   typedef enum logic [1:0] {
      PIN_GPIO_IN = 2'h0,
      PIN_GPIO_OUT = 2'h1,
      PIN_TIMER = 2'h2
   } pin_fn_e;

   // timer operating mode
   typedef enum logic [2:0] {
      MODE_TIMER = 3'h0,
      MODE_PULSE = 3'h1,
      MODE_WATCHDOG = 3'h2,
      MODE_EVENT = 3'h3,
      MODE_MEASURE = 3'h4
   } tmr_mode_e;

endpackage

// File: src/timer_channel.sv
// one timer channel: counter, compare, pin direction and drive
// assumes pin_in already synchronised to core_clk by the caller
`timescale 1ns/1ns
`include "timer_defs.svh"

module timer_channel (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // control/status bits
   input wire logic enable,
   input wire timer_pkg::pin_fn_e pin_fn,
   input wire timer_pkg::tmr_mode_e mode,
   input wire logic gpio_out_val,
   input wire logic [`TMR_CNT_W-1:0] compare_val,
   input wire logic [`TMR_PRESC_W-1:0] presc_val,
   input wire logic clear_done,
   // pin
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   // status
   output logic irq,
   output logic done,
   output logic [`TMR_CNT_W-1:0] count,
   output logic [`TMR_CNT_W-1:0] capture
);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } ch_state_e;

   ch_state_e state_r, state_nxt;
   logic [`TMR_CNT_W-1:0] cnt_r, cnt_nxt, cap_r, cap_nxt;
   logic [`TMR_PRESC_W-1:0] pre_r, pre_nxt;
   logic pin_d_r, pin_d_nxt, out_r, out_nxt, oe_r, oe_nxt;
   logic irq_r, irq_nxt, done_r, done_nxt;
   logic ext_mode, tick, rise, fall, hit;

   always_comb begin
      ext_mode = (mode == timer_pkg::MODE_EVENT) || (mode == timer_pkg::MODE_MEASURE);
      rise = pin_in && !pin_d_r;
      fall = !pin_in && pin_d_r;
      // internal source runs from a prescaler enable pulse, event mode from pin rising edges, measure mode from pin high level
      tick = ext_mode ? ((mode == timer_pkg::MODE_EVENT) ? rise : pin_in)
                      : (pre_r == presc_val);
      hit = tick && (cnt_r == compare_val);
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      cap_nxt = cap_r;
      pre_nxt = (pre_r == presc_val || ext_mode) ? `TMR_PRESC_RST
                                                 : pre_r + `TMR_PRESC_W'(1);
      pin_d_nxt = pin_in;
      out_nxt = out_r;
      irq_nxt = 1'b0;
      done_nxt = clear_done ? 1'b0 : done_r;
      case (state_r)
         ST_IDLE: begin
            cnt_nxt = `TMR_CNT_RST;
            pre_nxt = `TMR_PRESC_RST;
            out_nxt = 1'b0;
            if (enable && pin_fn == timer_pkg::PIN_TIMER)
               state_nxt = ST_RUN;
         end
         ST_RUN: begin
            if (!enable || pin_fn != timer_pkg::PIN_TIMER) begin
               state_nxt = ST_IDLE;
            end else if (mode == timer_pkg::MODE_MEASURE) begin
               // width of a high pulse on the pin, captured on its fall
               if (fall) begin
                  cap_nxt = cnt_r;
                  cnt_nxt = `TMR_CNT_RST;
                  irq_nxt = 1'b1;
                  done_nxt = 1'b1;
               end else if (tick) begin
                  cnt_nxt = cnt_r + `TMR_CNT_W'(1);
               end
            end else if (hit) begin
               cnt_nxt = `TMR_CNT_RST;
               irq_nxt = 1'b1;
               done_nxt = 1'b1; // set wins over clear
               // signal the outside party on the count match
               if (mode == timer_pkg::MODE_PULSE || mode == timer_pkg::MODE_TIMER)
                  out_nxt = !out_r;
               else if (mode == timer_pkg::MODE_WATCHDOG)
                  out_nxt = `TMR_PWM_HIGH;
            end else if (tick) begin
               cnt_nxt = cnt_r + `TMR_CNT_W'(1);
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      // direction follows pin function and mode
      case (pin_fn)
         timer_pkg::PIN_GPIO_OUT: begin
            oe_nxt = 1'b1;
            out_nxt = gpio_out_val;
         end
         timer_pkg::PIN_TIMER: oe_nxt = !ext_mode;
         default: oe_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
         cnt_r <= `TMR_CNT_RST;
         cap_r <= `TMR_CNT_RST;
         pre_r <= `TMR_PRESC_RST;
         pin_d_r <= 1'b0;
         out_r <= 1'b0;
         oe_r <= 1'b0;
         irq_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         cap_r <= cap_nxt;
         pre_r <= pre_nxt;
         pin_d_r <= pin_d_nxt;
         out_r <= out_nxt;
         oe_r <= oe_nxt;
         irq_r <= irq_nxt;
         done_r <= done_nxt;
      end
   end

   assign pin_out = out_r;
   assign pin_oe = oe_r;
   assign irq = irq_r;
   assign done = done_r;
   assign count = cnt_r;
   assign capture = cap_r;

endmodule // timer_channel

// File: src/triple_timer_pin_control.sv
// three independent timer channels with one two-way pin each
// assumes control bits are driven by core_clk logic; pins are asynchronous
//
// Functional notes
// - three identical independent channels, internal or external event clocking
// - each channel pulses an interrupt after the programmed count, in measurement mode on the pin's fall instead
// - each channel signals on its pin after a programmed internal count
// - event counter and measurement modes make the pin an input
// - watchdog, timer and pulse modes drive the pin as output
// - after reset pins are gpio inputs; control bits reconfigure them
`timescale 1ns/1ns
`include "timer_defs.svh"

module triple_timer_pin_control (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // per-channel control/status bits (timer_ctrl_stat_ch0..2)
   input wire logic [`TMR_CH_COUNT-1:0] tmr_enable,
   input wire timer_pkg::pin_fn_e pin_fn_ch0,
   input wire timer_pkg::pin_fn_e pin_fn_ch1,
   input wire timer_pkg::pin_fn_e pin_fn_ch2,
   input wire timer_pkg::tmr_mode_e mode_ch0,
   input wire timer_pkg::tmr_mode_e mode_ch1,
   input wire timer_pkg::tmr_mode_e mode_ch2,
   input wire logic [`TMR_CH_COUNT-1:0] gpio_out_val,
   input wire logic [`TMR_CNT_W-1:0] compare_ch0,
   input wire logic [`TMR_CNT_W-1:0] compare_ch1,
   input wire logic [`TMR_CNT_W-1:0] compare_ch2,
   input wire logic [`TMR_PRESC_W-1:0] presc_ch0,
   input wire logic [`TMR_PRESC_W-1:0] presc_ch1,
   input wire logic [`TMR_PRESC_W-1:0] presc_ch2,
   input wire logic [`TMR_CH_COUNT-1:0] clear_done,
   // timer pins timer_pin_ch0..2
   input wire logic [`TMR_CH_COUNT-1:0] timer_pin_in,
   output logic [`TMR_CH_COUNT-1:0] timer_pin_out,
   output logic [`TMR_CH_COUNT-1:0] timer_pin_oe,
   // status
   output logic [`TMR_CH_COUNT-1:0] tmr_irq,
   output logic [`TMR_CH_COUNT-1:0] tmr_done,
   output logic [`TMR_CH_COUNT-1:0] gpio_in_val,
   output logic [`TMR_CNT_W-1:0] count_ch0,
   output logic [`TMR_CNT_W-1:0] count_ch1,
   output logic [`TMR_CNT_W-1:0] count_ch2,
   output logic [`TMR_CNT_W-1:0] capture_ch0,
   output logic [`TMR_CNT_W-1:0] capture_ch1,
   output logic [`TMR_CNT_W-1:0] capture_ch2
);

   logic [`TMR_CH_COUNT-1:0] meta_r, meta_nxt, sync_r, sync_nxt, gin_r, gin_nxt;

   always_comb begin
      meta_nxt = timer_pin_in;
      sync_nxt = meta_r;
      gin_nxt = sync_r;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         meta_r <= 3'h0;
         sync_r <= 3'h0;
         gin_r <= 3'h0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         gin_r <= gin_nxt;
      end
   end

   assign gpio_in_val = gin_r;

   // three identical channels share one module
   timer_channel u_ch0 (
      .core_clk(core_clk), .rstn(rstn), .enable(tmr_enable[0]), .pin_fn(pin_fn_ch0),
      .mode(mode_ch0), .gpio_out_val(gpio_out_val[0]), .compare_val(compare_ch0),
      .presc_val(presc_ch0), .clear_done(clear_done[0]), .pin_in(sync_r[0]),
      .pin_out(timer_pin_out[0]), .pin_oe(timer_pin_oe[0]), .irq(tmr_irq[0]),
      .done(tmr_done[0]), .count(count_ch0), .capture(capture_ch0)
   );

   timer_channel u_ch1 (
      .core_clk(core_clk), .rstn(rstn), .enable(tmr_enable[1]), .pin_fn(pin_fn_ch1),
      .mode(mode_ch1), .gpio_out_val(gpio_out_val[1]), .compare_val(compare_ch1),
      .presc_val(presc_ch1), .clear_done(clear_done[1]), .pin_in(sync_r[1]),
      .pin_out(timer_pin_out[1]), .pin_oe(timer_pin_oe[1]), .irq(tmr_irq[1]),
      .done(tmr_done[1]), .count(count_ch1), .capture(capture_ch1)
   );

   timer_channel u_ch2 (
      .core_clk(core_clk), .rstn(rstn), .enable(tmr_enable[2]), .pin_fn(pin_fn_ch2),
      .mode(mode_ch2), .gpio_out_val(gpio_out_val[2]), .compare_val(compare_ch2),
      .presc_val(presc_ch2), .clear_done(clear_done[2]), .pin_in(sync_r[2]),
      .pin_out(timer_pin_out[2]), .pin_oe(timer_pin_oe[2]), .irq(tmr_irq[2]),
      .done(tmr_done[2]), .count(count_ch2), .capture(capture_ch2)
   );

endmodule // triple_timer_pin_control

// File: test/tmr_checker_properties.sv
// checker for channel 0 pin direction, interrupt, done flag and pin drive
// assumes it is bound to triple_timer_pin_control and sees only its ports
`timescale 1ns/1ns
module tmr_checker (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // controls
   input wire logic [2:0] tmr_enable,
   input wire timer_pkg::pin_fn_e pin_fn_ch0,
   input wire timer_pkg::tmr_mode_e mode_ch0,
   input wire logic [2:0] gpio_out_val,
   input wire logic [2:0] clear_done,
   // outputs
   input wire logic [2:0] timer_pin_out,
   input wire logic [2:0] timer_pin_oe,
   input wire logic [2:0] tmr_irq,
   input wire logic [2:0] tmr_done
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   wire logic tf = pin_fn_ch0 == timer_pkg::PIN_TIMER;
   wire logic tin = tf && mode_ch0 inside {timer_pkg::MODE_EVENT, timer_pkg::MODE_MEASURE};
   wire logic wd = tf && mode_ch0 == timer_pkg::MODE_WATCHDOG && tmr_enable[0];
   sequence s_wd_high; wd && timer_pin_out[0]; endsequence
   sequence s_wd_held; wd; endsequence
   property p_fn_in; (pin_fn_ch0 == timer_pkg::PIN_GPIO_IN) [*2] |-> !timer_pin_oe[0]; endproperty
   a_fn_in: assert property (p_fn_in) else $error("gpio input pin driven");
   property p_fn_out;
      (pin_fn_ch0 == timer_pkg::PIN_GPIO_OUT && gpio_out_val[0]) [*2] |->
         timer_pin_oe[0] && timer_pin_out[0];
   endproperty
   a_fn_out: assert property (p_fn_out) else $error("gpio output not driven");
   property p_in_mode; tin [*2] |-> !timer_pin_oe[0]; endproperty
   a_in_mode: assert property (p_in_mode) else $error("input mode pin driven");
   property p_out_mode; (tf && !tin) [*2] |-> timer_pin_oe[0]; endproperty
   a_out_mode: assert property (p_out_mode) else $error("output mode pin released");
   property p_irq_done; tmr_irq[0] |-> tmr_done[0]; endproperty
   a_irq_done: assert property (p_irq_done) else $error("irq without done");
   property p_done_hold; tmr_done[0] && !clear_done[0] |=> tmr_done[0]; endproperty
   a_done_hold: assert property (p_done_hold) else $error("done lost");
   property p_wd; s_wd_high ##1 s_wd_held |-> timer_pin_out[0]; endproperty
   a_wd: assert property (p_wd) else $error("watchdog pin dropped");
   property p_toggle;
      tf && mode_ch0 == timer_pkg::MODE_TIMER && tmr_irq[0] |->
         timer_pin_out[0] != $past(timer_pin_out[0]);
   endproperty
   a_toggle: assert property (p_toggle) else $error("timer pin not toggled");
endmodule // tmr_checker

bind triple_timer_pin_control tmr_checker tmr_checker_i (.*);

// File: test/pin_partner.sv
// far-side pin model: external source that yields each pin while the block drives it
// assumes oe high means the block drives the pin
`timescale 1ns/1ns
module pin_partner (
   // block side
   input wire logic [2:0] pin_oe,
   input wire logic [2:0] pin_out,
   // external side
   input wire logic [2:0] ext_level,
   output logic [2:0] pin_level
);
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pin_partner

// File: test/tb_triple_timer_pin_control.sv
// bench for the triple timer: direction, periods, watchdog, events, width capture
// assumes the checker is bound in its own file and pin_partner closes the pin loops
`timescale 1ns/1ns
module tb_triple_timer_pin_control;
   logic core_clk = 0, rstn = 0;
   logic [2:0] tmr_enable = 0, gpio_out_val = 0, clear_done = 0, ext = 0;
   timer_pkg::pin_fn_e pin_fn_ch0 = timer_pkg::PIN_GPIO_IN, pin_fn_ch1 = timer_pkg::PIN_GPIO_IN;
   timer_pkg::pin_fn_e pin_fn_ch2 = timer_pkg::PIN_GPIO_IN;
   timer_pkg::tmr_mode_e mode_ch0 = timer_pkg::MODE_TIMER, mode_ch1 = timer_pkg::MODE_TIMER;
   timer_pkg::tmr_mode_e mode_ch2 = timer_pkg::MODE_TIMER;
   logic [23:0] compare_ch0 = 24'h1, compare_ch1 = 24'h7, compare_ch2 = 24'h2;
   logic [7:0] presc_ch0 = 8'h0, presc_ch1 = 8'h0, presc_ch2 = 8'h0;
   logic [2:0] timer_pin_in, timer_pin_out, timer_pin_oe, tmr_irq, tmr_done, gpio_in_val;
   logic [23:0] count_ch0, count_ch1, count_ch2, capture_ch0, capture_ch1, capture_ch2;
   int fail_count = 0, n_tests = 0;
   triple_timer_pin_control triple_timer_pin_control_i (.*);
   pin_partner pin_partner_i (.pin_oe(timer_pin_oe), .pin_out(timer_pin_out),
      .ext_level(ext), .pin_level(timer_pin_in));
   initial forever #4 core_clk = ~core_clk;
   task automatic chk(input logic [23:0] g, e);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wirq(input int ch);
      int n;
      n = 0;
      do begin @(negedge core_clk); n++; end while (tmr_irq[ch] !== 1'b1 && n < 99);
      chk(n < 99, 1);
   endtask
   task automatic per(input int ch, input logic [23:0] e);
      logic [23:0] c;
      c = 0;
      wirq(ch);
      do begin @(negedge core_clk); c++; end while (tmr_irq[ch] !== 1'b1 && c < 99);
      chk(c, e);
   endtask
   task automatic pulse(input logic [2:0] m, input int n);
      @(posedge core_clk);
      ext <= m;
      repeat (n) @(posedge core_clk);
      ext <= 3'h0;
      repeat (n) @(posedge core_clk);
   endtask
   task automatic conclude;
      $display("tests %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #100000;
      fail_count++;
      conclude;
   end
   initial begin
      repeat (5) @(posedge core_clk);
      rstn <= 1;
      @(negedge core_clk);
      chk(timer_pin_oe, 3'h0);
      @(posedge core_clk);
      pin_fn_ch0 <= timer_pkg::PIN_GPIO_OUT;
      gpio_out_val <= 3'h1;
      repeat (3) @(negedge core_clk);
      chk({timer_pin_oe[0], timer_pin_out[0]}, 2'h3);
      $display("test gpio done");
      @(posedge core_clk);
      pin_fn_ch0 <= timer_pkg::PIN_TIMER;
      pin_fn_ch1 <= timer_pkg::PIN_TIMER;
      pin_fn_ch2 <= timer_pkg::PIN_TIMER;
      tmr_enable <= 3'h7;
      per(0, 24'h2);
      per(1, 24'h8);
      per(2, 24'h3);
      chk(timer_pin_oe, 3'h7);
      @(posedge core_clk);
      mode_ch0 <= timer_pkg::MODE_WATCHDOG;
      wirq(0);
      repeat (4) @(negedge core_clk);
      chk(timer_pin_out[0], 1'h1);
      $display("test timer done");
      @(posedge core_clk);
      tmr_enable <= 3'h0;
      mode_ch0 <= timer_pkg::MODE_MEASURE;
      mode_ch1 <= timer_pkg::MODE_EVENT;
      mode_ch2 <= timer_pkg::MODE_MEASURE;
      @(posedge core_clk);
      tmr_enable <= 3'h7;
      repeat (3) @(negedge core_clk);
      chk(timer_pin_oe, 3'h0);
      repeat (3) pulse(3'h2, 3);
      repeat (4) @(negedge core_clk);
      chk(count_ch1, 24'h3);
      // clear stale flags, then measure a ten-clock high pulse on channels 0 and 2
      @(posedge core_clk);
      clear_done <= 3'h7;
      @(posedge core_clk);
      clear_done <= 3'h0;
      @(negedge core_clk);
      chk(tmr_done, 3'h0);
      pulse(3'h5, 10);
      @(negedge core_clk);
      chk(tmr_done, 3'h5);
      chk(capture_ch0, 24'hA);
      chk(capture_ch2, 24'hA);
      chk(count_ch0, 24'h0);
      chk(count_ch2, 24'h0);
      chk(capture_ch1, 24'h0);
      @(posedge core_clk);
      pin_fn_ch1 <= timer_pkg::PIN_GPIO_IN;
      ext <= 3'h2;
      repeat (6) @(negedge core_clk);
      chk(gpio_in_val[1], 1'h1);
      $display("test input done");
      conclude;
   end
endmodule // tb_triple_timer_pin_control
